/* rtl/dsv_pkg.sv */
// Purpose: shared constants and carriers for the destination register set view
// Assumes: 32-bit apb data, one aligned word per register
// Notes: offsets below are byte addresses
`default_nettype none
package dsv_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_SRC_REF = 12'h000;
	localparam logic [11:0] OFS_DST_REF = 12'h004;
	localparam logic [11:0] OFS_OPTIONS = 12'h008;
	localparam logic [11:0] OFS_SRC_ADDR = 12'h00C;
	localparam logic [11:0] OFS_COUNTS = 12'h010;
	localparam logic [11:0] OFS_CUR_ADDR = 12'h014;
	localparam logic [11:0] OFS_RELOAD = 12'h018;
	localparam logic [11:0] OFS_INDEX = 12'h01C;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h020;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h024;
	// option field positions
	localparam int OPT_CHAIN_BIT = 22;
	localparam int OPT_IRQ_BIT = 20;
	localparam int OPT_CODE_LSB = 12;
	localparam int OPT_FIFO_WIDTH_SELECT_LSB = 8;
	localparam int OPT_PRI_LSB = 4;
	localparam int OPT_DAM_BIT = 1;
	localparam int OPT_SAM_BIT = 0;
	// writable option bits; everything else reads zero
	localparam logic [31:0] OPT_WRITE_MASK = 32'h0053F773;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [2:0] FIFO_WIDTH_SELECT_MAX_CODE = 3'h4;
	// status bits of the interrupt register
	localparam int EV_DONE = 0;
	localparam int EV_ARRAY = 1;
	localparam int EV_BADWID = 2;
	localparam int EV_WIDTH = 3;

	// transfer request as submitted by the channel controller
	typedef struct packed {
		logic [31:0] options;
		logic [31:0] dest_addr;
		logic [15:0] array_count;
		logic [15:0] array_byte_count;
		logic [15:0] dest_array_index;
	} dsv_request_t;

	// completion notice to the channel controller
	typedef struct packed {
		logic chain;
		logic irq;
		logic [5:0] code;
	} dsv_done_t;

	// progress states
	typedef enum logic [1:0] {
		DSV_IDLE = 2'b00,
		DSV_BUSY = 2'b01,
		DSV_NEXT = 2'b11,
		DSV_DONE = 2'b10
	} dsv_state_t;
endpackage : dsv_pkg
`default_nettype wire

/* rtl/dsv_regset.sv */
// Purpose: destination-side register set of a dma transfer controller
// Assumes: requests arrive only while idle; write beats reported by the datapath
// Notes: registers are read over apb; options are also writable while idle
// What this block does
// - source address and reference always read zero
// - hold reference address of current array
// - option bit 22 enables completion chaining
// - option bit 20 enables completion interrupt
// - six-bit completion code in bits 17:12
// - fifo width codes 0-4, 5-7 reserved
// - three-bit priority, zero highest
// - bit 1 destination increment or constant
// - bit 0 source increment or constant
// - upper count holds arrays left
// - lower count holds bytes left
// - current address points at next write, last write once an array ends
// - reload byte count after each array except the last
// - destination index spaces successive arrays
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module dsv_regset #(
	parameter int BEAT_MAX = 16
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// request submission
	input wire logic req_valid,
	input wire dsv_pkg::dsv_request_t req,
	output logic req_ready,
	// write beats from the datapath
	input wire logic beat_valid,
	input wire logic [4:0] beat_bytes,
	// state toward the datapath
	output logic busy,
	output logic [31:0] write_addr,
	output logic [2:0] transfer_priority,
	output logic [7:0] fifo_width_bits,
	// completion toward the channel controller
	output var dsv_pkg::dsv_done_t done_info,
	output logic done_pulse,
	// interrupt
	output logic irq
);
	// refuse a BEAT_MAX outside 1 to 16 bytes, the widest fifo width
	if (BEAT_MAX < 1 || BEAT_MAX > 16) begin : gen_beat_max_check
		$error("BEAT_MAX out of range");
	end

	dsv_pkg::dsv_state_t state;
	logic [31:0] options;
	logic [31:0] dest_ref;
	logic [31:0] cur_addr;
	logic [15:0] array_count;
	logic [15:0] array_byte_count;
	logic [15:0] array_byte_count_reload;
	logic [15:0] dest_array_index;
	logic [3:0] irq_status;
	logic [3:0] irq_mask;
	logic [3:0] events;
	logic [4:0] fifo_bytes;
	logic [31:0] wrap_off;
	logic [31:0] next_cur_addr;
	logic array_end;
	logic wid_bad;
	logic apb_wr;
	logic apb_rd;
	logic [31:0] rd_word;

	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign req_ready = (state == dsv_pkg::DSV_IDLE);
	assign busy = (state != dsv_pkg::DSV_IDLE);
	assign write_addr = cur_addr;
	assign transfer_priority = options[dsv_pkg::OPT_PRI_LSB +: 3];

	// fifo width decode; reserved codes fall back to eight bits
	always_comb begin
		wid_bad = 1'b0;
		case (options[dsv_pkg::OPT_FIFO_WIDTH_SELECT_LSB +: 3])
			3'h0: fifo_bytes = 5'h01;
			3'h1: fifo_bytes = 5'h02;
			3'h2: fifo_bytes = 5'h04;
			3'h3: fifo_bytes = 5'h08;
			3'h4: fifo_bytes = 5'h10;
			default: begin
				fifo_bytes = 5'h01;
				wid_bad = 1'b1;
			end
		endcase
	end
	assign fifo_width_bits = {fifo_bytes, 3'h0};

	// beat finishing the current array
	assign array_end = beat_valid && (state == dsv_pkg::DSV_BUSY) &&
		({11'h000, beat_bytes} >= array_byte_count);

	// constant mode wraps inside the fifo window, offset kept from reference
	assign wrap_off = (cur_addr - dest_ref + {27'h0, beat_bytes}) & {27'h0, fifo_bytes - 5'h01};
	always_comb begin
		if (options[dsv_pkg::OPT_DAM_BIT]) begin
			next_cur_addr = dest_ref + wrap_off;
		end else begin
			next_cur_addr = cur_addr + {27'h0, beat_bytes};
		end
	end

	// progress state machine
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= dsv_pkg::DSV_IDLE;
		end else begin
			case (state)
				dsv_pkg::DSV_IDLE: if (req_valid) state <= dsv_pkg::DSV_BUSY;
				dsv_pkg::DSV_BUSY: if (array_end) state <= dsv_pkg::DSV_NEXT;
				dsv_pkg::DSV_NEXT: begin
					if (array_count <= 16'h0001) state <= dsv_pkg::DSV_DONE;
					else state <= dsv_pkg::DSV_BUSY;
				end
				dsv_pkg::DSV_DONE: state <= dsv_pkg::DSV_IDLE;
				default: state <= dsv_pkg::DSV_IDLE;
			endcase
		end
	end

	// options: loaded by a request, writable by software only while idle
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			options <= dsv_pkg::RESET_WORD;
		end else if (state == dsv_pkg::DSV_IDLE && req_valid) begin
			options <= req.options & dsv_pkg::OPT_WRITE_MASK;
		end else if (state == dsv_pkg::DSV_IDLE && apb_wr && paddr == dsv_pkg::OFS_OPTIONS) begin
			options <= pwdata & dsv_pkg::OPT_WRITE_MASK;
		end
	end

	// counts and reload value
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			array_count <= 16'h0000;
			array_byte_count <= 16'h0000;
			array_byte_count_reload <= 16'h0000;
			dest_array_index <= 16'h0000;
		end else if (state == dsv_pkg::DSV_IDLE && req_valid) begin
			array_count <= req.array_count;
			array_byte_count <= req.array_byte_count;
			array_byte_count_reload <= req.array_byte_count;
			dest_array_index <= req.dest_array_index;
		end else if (state == dsv_pkg::DSV_NEXT) begin
			array_count <= array_count - 16'h0001;
			if (array_count > 16'h0001) array_byte_count <= array_byte_count_reload;
		end else if (array_end) begin
			array_byte_count <= 16'h0000;
		end else if (beat_valid && state == dsv_pkg::DSV_BUSY) begin
			array_byte_count <= array_byte_count - {11'h000, beat_bytes};
		end
	end

	// addresses; the last beat's address stays until the next array starts
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dest_ref <= 32'h00000000;
			cur_addr <= 32'h00000000;
		end else if (state == dsv_pkg::DSV_IDLE && req_valid) begin
			dest_ref <= req.dest_addr;
			cur_addr <= req.dest_addr;
		end else if (state == dsv_pkg::DSV_NEXT && array_count > 16'h0001) begin
			dest_ref <= dest_ref + {16'h0000, dest_array_index};
			cur_addr <= dest_ref + {16'h0000, dest_array_index};
		end else if (beat_valid && state == dsv_pkg::DSV_BUSY && !array_end) begin
			cur_addr <= next_cur_addr;
		end
	end

	// completion notice, one cycle in the done state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			done_info <= '0;
			done_pulse <= 1'b0;
		end else begin
			done_pulse <= (state == dsv_pkg::DSV_NEXT) && (array_count <= 16'h0001);
			if ((state == dsv_pkg::DSV_NEXT) && (array_count <= 16'h0001)) begin
				done_info.chain <= options[dsv_pkg::OPT_CHAIN_BIT];
				done_info.irq <= options[dsv_pkg::OPT_IRQ_BIT];
				done_info.code <= options[dsv_pkg::OPT_CODE_LSB +: 6];
			end else begin
				done_info <= '0;
			end
		end
	end

	// sticky events; a new event beats the clear-on-read
	assign events[dsv_pkg::EV_DONE] = (state == dsv_pkg::DSV_DONE);
	assign events[dsv_pkg::EV_ARRAY] = (state == dsv_pkg::DSV_NEXT);
	assign events[dsv_pkg::EV_BADWID] = wid_bad && busy &&
		(options[dsv_pkg::OPT_DAM_BIT] || options[dsv_pkg::OPT_SAM_BIT]);
	assign events[dsv_pkg::EV_WIDTH] = 1'b0;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_status <= 4'h0;
		end else if (apb_rd && paddr == dsv_pkg::OFS_IRQ_STATUS) begin
			irq_status <= events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// interrupt mask
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_mask <= 4'h0;
		end else if (apb_wr && paddr == dsv_pkg::OFS_IRQ_MASK) begin
			irq_mask <= pwdata[3:0];
		end
	end
	assign irq = |(irq_status & irq_mask);

	// read mux; unmapped addresses answer with an error
	always_comb begin
		pslverr = 1'b0;
		case (paddr)
			dsv_pkg::OFS_SRC_REF: rd_word = 32'h00000000;
			dsv_pkg::OFS_SRC_ADDR: rd_word = 32'h00000000;
			dsv_pkg::OFS_DST_REF: rd_word = dest_ref;
			dsv_pkg::OFS_OPTIONS: rd_word = options & dsv_pkg::OPT_WRITE_MASK;
			dsv_pkg::OFS_COUNTS: rd_word = {array_count, array_byte_count};
			dsv_pkg::OFS_CUR_ADDR: rd_word = cur_addr;
			dsv_pkg::OFS_RELOAD: rd_word = {16'h0000, array_byte_count_reload};
			dsv_pkg::OFS_INDEX: rd_word = {dest_array_index, 16'h0000};
			dsv_pkg::OFS_IRQ_STATUS: rd_word = {28'h0000000, irq_status};
			dsv_pkg::OFS_IRQ_MASK: rd_word = {28'h0000000, irq_mask};
			default: begin
				rd_word = 32'h00000000;
				pslverr = psel && penable;
			end
		endcase
	end
	assign prdata = apb_rd ? rd_word : 32'h00000000;

	// checks
	AST_SRC_ZERO: assert property (@(posedge core_clk) disable iff (reset)
		(apb_rd && (paddr == dsv_pkg::OFS_SRC_REF || paddr == dsv_pkg::OFS_SRC_ADDR)) |-> prdata == 32'h0)
		else $error("source field read nonzero");
	AST_REF_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> dest_ref == $past(req.dest_addr))
		else $error("reference not loaded");
	AST_CHAIN: assert property (@(posedge core_clk) disable iff (reset)
		done_pulse |-> done_info.chain == options[22])
		else $error("chain flag wrong");
	AST_IRQEN: assert property (@(posedge core_clk) disable iff (reset)
		done_pulse |-> done_info.irq == options[20])
		else $error("irq enable wrong");
	AST_CODE: assert property (@(posedge core_clk) disable iff (reset)
		done_pulse |-> done_info.code == options[17:12])
		else $error("completion code wrong");
	AST_FIFO_WIDTH_SELECT: assert property (@(posedge core_clk) disable iff (reset)
		options[10:8] == 3'h4 |-> fifo_width_bits == 8'h80)
		else $error("width decode wrong");
	AST_RELOAD: assert property (@(posedge core_clk) disable iff (reset)
		(state == dsv_pkg::DSV_NEXT && array_count > 16'h0001) |=> array_byte_count == array_byte_count_reload)
		else $error("byte count not reloaded");
	AST_ADVANCE: assert property (@(posedge core_clk) disable iff (reset)
		(state == dsv_pkg::DSV_NEXT && array_count > 16'h0001) |=>
		(dest_ref == $past(dest_ref) + {16'h0, $past(dest_array_index)} && cur_addr == dest_ref
		&& array_count == $past(array_count) - 16'h0001))
		else $error("array advance wrong");
	AST_RSVD: assert property (@(posedge core_clk) disable iff (reset)
		(options & ~dsv_pkg::OPT_WRITE_MASK) == 32'h0)
		else $error("reserved option bit set");
	AST_DONE_SEQ: assert property (@(posedge core_clk) disable iff (reset)
		done_pulse |-> state == dsv_pkg::DSV_DONE ##1 state == dsv_pkg::DSV_IDLE)
		else $error("completion sequence wrong");

	// a taken request loads every field in one edge
	AST_CNT_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> array_count == $past(req.array_count))
		else $error("array count not loaded");

	AST_BYTES_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> array_byte_count == $past(req.array_byte_count))
		else $error("byte count not loaded");

	AST_RELOAD_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> array_byte_count_reload == $past(req.array_byte_count))
		else $error("reload value not loaded");

	AST_INDEX_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> dest_array_index == $past(req.dest_array_index))
		else $error("index not loaded");

	AST_CUR_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> cur_addr == $past(req.dest_addr))
		else $error("current address not loaded");

	AST_OPT_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> options == ($past(req.options) & dsv_pkg::OPT_WRITE_MASK))
		else $error("options not loaded");

	// refusal while a transfer runs, and no beat counted while idle
	AST_BUSY_START: assert property (@(posedge core_clk) disable iff (reset)
		(req_valid && req_ready) |=> (busy && !req_ready))
		else $error("request did not start work");

	AST_REFUSED: assert property (@(posedge core_clk) disable iff (reset)
		(state == dsv_pkg::DSV_BUSY && req_valid) |=> array_count == $past(array_count))
		else $error("request taken while busy");

	AST_OPT_FROZEN: assert property (@(posedge core_clk) disable iff (reset)
		(state != dsv_pkg::DSV_IDLE) |=> options == $past(options))
		else $error("options changed while busy");

	AST_IDLE_BEAT: assert property (@(posedge core_clk) disable iff (reset)
		(state == dsv_pkg::DSV_IDLE && !req_valid) |=> array_byte_count == $past(array_byte_count))
		else $error("idle beat counted");

	// beats within an array
	AST_BEAT_BYTES: assert property (@(posedge core_clk) disable iff (reset)
		(beat_valid && state == dsv_pkg::DSV_BUSY && !array_end) |=>
		array_byte_count == $past(array_byte_count) - {11'h000, $past(beat_bytes)})
		else $error("byte count not decremented");

	AST_BEAT_INCREMENT_ADDRESSING: assert property (@(posedge core_clk) disable iff (reset)
		(beat_valid && state == dsv_pkg::DSV_BUSY && !array_end && !options[1]) |=>
		cur_addr == $past(cur_addr) + {27'h0, $past(beat_bytes)})
		else $error("address not incremented");

	AST_BEAT_CONST: assert property (@(posedge core_clk) disable iff (reset)
		(busy && options[1]) |-> (cur_addr - dest_ref) < {27'h0, fifo_bytes})
		else $error("constant address left its window");

	AST_END_ZERO: assert property (@(posedge core_clk) disable iff (reset)
		array_end |=> (array_byte_count == 16'h0000 && state == dsv_pkg::DSV_NEXT))
		else $error("array end not taken");

	AST_LAST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		array_end |=> cur_addr == $past(cur_addr))
		else $error("last write address lost");

	AST_LAST_ARRAY: assert property (@(posedge core_clk) disable iff (reset)
		(state == dsv_pkg::DSV_NEXT && array_count <= 16'h0001) |=>
		(state == dsv_pkg::DSV_DONE && dest_ref == $past(dest_ref) && done_pulse))
		else $error("last array not completed");

	// width decode corners
	AST_FIFO_WIDTH_SELECT_RSVD: assert property (@(posedge core_clk) disable iff (reset)
		(options[10:8] > 3'h4) |-> (fifo_width_bits == 8'h08 && wid_bad))
		else $error("reserved width not flagged");

	AST_FIFO_WIDTH_SELECT_BYTE: assert property (@(posedge core_clk) disable iff (reset)
		(options[10:8] == 3'h0) |-> (fifo_width_bits == 8'h08 && !wid_bad))
		else $error("byte width decode wrong");

	AST_SRC_MODE_EVENT: assert property (@(posedge core_clk) disable iff (reset)
		(busy && wid_bad && options[0]) |=> irq_status[dsv_pkg::EV_BADWID])
		else $error("width event not raised");

	// completion notice and read data stay quiet outside their cycle
	AST_DONE_ONE: assert property (@(posedge core_clk) disable iff (reset)
		done_pulse |=> !done_pulse)
		else $error("completion pulse too long");

	AST_INFO_QUIET: assert property (@(posedge core_clk) disable iff (reset)
		!done_pulse |-> done_info == '0)
		else $error("completion info without pulse");

	AST_RD_QUIET: assert property (@(posedge core_clk) disable iff (reset)
		!apb_rd |-> prdata == 32'h00000000)
		else $error("read data outside a read");
endmodule : dsv_regset
`default_nettype wire

/* tb/dsv_chan_model.sv */
// Purpose: channel controller model that submits requests and reports write beats
// Assumes: one request at a time, taken only while the register set is idle
// Notes: released lines carry inverted data so a stale value never passes for a fresh one
`default_nettype none
module dsv_chan_model (
	// clock
	input wire logic core_clk,
	// request submission
	output logic req_valid,
	output var dsv_pkg::dsv_request_t req,
	input wire logic req_ready,
	// write beats
	output logic beat_valid,
	output logic [4:0] beat_bytes
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet lines from time zero
	initial begin
		req_valid = 1'b0;
		req = '0;
		beat_valid = 1'b0;
		beat_bytes = 5'h00;
	end

	// hold the request until an edge sees it taken, then scramble it
	task automatic send(input dsv_pkg::dsv_request_t r);
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= r;
		do @(posedge core_clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		req <= ~r;
	endtask : send

	// one beat after a stall of gap cycles, so slow datapaths are modelled too
	task automatic beat(input logic [4:0] n, input int gap);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		beat_valid <= 1'b1;
		beat_bytes <= n;
		@(posedge core_clk);
		beat_valid <= 1'b0;
		beat_bytes <= ~n;
	endtask : beat
endmodule : dsv_chan_model
`default_nettype wire

/* tb/dma_dest_register_set_view_tb.sv */
// Purpose: self-checking bench for the destination register set
// Assumes: zero-wait apb slave, request accepted only while idle
// Notes: a two-array transfer and a constant-mode one; option fields swept with random filler
`default_nettype none
module dma_dest_register_set_view_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, write_addr, opt, a, q;
	logic pready, pslverr, req_valid, req_ready, beat_valid, busy, done_pulse, irq, err;
	logic [4:0] beat_bytes;
	logic [2:0] transfer_priority;
	logic [7:0] fifo_width_bits;
	logic [15:0] idx;
	dsv_pkg::dsv_request_t req;
	dsv_pkg::dsv_done_t done_info;
	int num_errors = 0;
	int n_checks = 0;

	// 200 MHz
	always #2.5 core_clk = ~core_clk;

	dsv_regset #(.BEAT_MAX(16)) dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .beat_valid(beat_valid),
		.beat_bytes(beat_bytes), .busy(busy), .write_addr(write_addr), .transfer_priority(transfer_priority),
		.fifo_width_bits(fifo_width_bits), .done_info(done_info), .done_pulse(done_pulse), .irq(irq));
	dsv_chan_model pm_u (.core_clk(core_clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
		.beat_valid(beat_valid), .beat_bytes(beat_bytes));

	// reserved width codes fall back to the narrowest width
	function automatic logic [7:0] fw(input logic [2:0] c);
		return (c <= 3'h4) ? (8'h08 << c) : 8'h08;
	endfunction : fw

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask : chk

	// apb cycle held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
		output logic [31:0] rq, output logic e);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rq = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		apb(1'b1, ad, d, q, err);
	endtask : wr

	task automatic rd(input logic [11:0] ad, input logic [31:0] e);
		apb(1'b0, ad, 32'h00000000, q, err);
		chk($sformatf("reg %h", ad), e, q);
		chk("slverr", 32'h00000000, {31'h0, err});
	endtask : rd

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : print_verdict

	// a hang counts as a mismatch
	initial begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		print_verdict();
	end

	// main sequence
	initial begin
		void'($urandom(56));
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		for (int i = 0; i < 10; i++) rd(12'(4 * i), 32'h00000000);
		apb(1'b0, 12'h028, 32'h00000000, q, err);
		chk("unmapped slverr", 32'h00000001, {31'h0, err});
		wr(dsv_pkg::OFS_SRC_ADDR, 32'hFFFFFFFF);
		rd(dsv_pkg::OFS_SRC_ADDR, 32'h00000000);
		chk("req ready idle", 32'h00000001, {31'h0, req_ready});
		$display("test reset done");
		// every width and priority code, random elsewhere
		for (int i = 0; i < 8; i++) begin
			opt = $urandom;
			opt[10:8] = i[2:0];
			opt[6:4] = i[2:0];
			wr(dsv_pkg::OFS_OPTIONS, opt);
			rd(dsv_pkg::OFS_OPTIONS, opt & dsv_pkg::OPT_WRITE_MASK);
			chk("priority", {29'h0, opt[6:4]}, {29'h0, transfer_priority});
			chk("fifo width", {24'h0, fw(opt[10:8])}, {24'h0, fifo_width_bits});
		end
		$display("test options done");
		// two arrays, incrementing mode so no width event muddies the status
		a = $urandom & 32'hFFFFFFFC;
		idx = 16'($urandom) & 16'hFFFC;
		opt = $urandom & dsv_pkg::OPT_WRITE_MASK & 32'hFFFFFFFC;
		wr(dsv_pkg::OFS_IRQ_MASK, 32'h00000001);
		pm_u.send({opt, a, 16'h0002, 16'h0008, idx});
		#1 chk("busy", 32'h00000001, {31'h0, busy});
		chk("req ready busy", 32'h00000000, {31'h0, req_ready});
		pm_u.beat(5'h04, $urandom % 3);
		#1 chk("write addr", a + 32'h4, write_addr);
		rd(dsv_pkg::OFS_COUNTS, 32'h00020004);
		wr(dsv_pkg::OFS_OPTIONS, 32'hFFFFFFFF);
		rd(dsv_pkg::OFS_OPTIONS, opt);
		pm_u.beat(5'h10, 0);
		#1 chk("held addr", a + 32'h4, write_addr);
		rd(dsv_pkg::OFS_DST_REF, a + {16'h0, idx});
		rd(dsv_pkg::OFS_RELOAD, 32'h00000008);
		rd(dsv_pkg::OFS_COUNTS, 32'h00010008);
		chk("next addr", a + {16'h0, idx}, write_addr);
		chk("masked irq", 32'h00000000, {31'h0, irq});
		rd(dsv_pkg::OFS_SRC_REF, 32'h00000000);
		pm_u.beat(5'h08, 2);
		for (int i = 0; i < 8 && done_pulse !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		chk("done pulse", 32'h00000001, {31'h0, done_pulse});
		chk("done info", {24'h0, opt[22], opt[20], opt[17:12]}, {24'h0, done_info});
		@(posedge core_clk);
		#1 chk("irq", 32'h00000001, {31'h0, irq});
		chk("final addr", a + {16'h0, idx}, write_addr);
		rd(dsv_pkg::OFS_IRQ_STATUS, 32'h00000003);
		#1 chk("irq cleared", 32'h00000000, {31'h0, irq});
		rd(dsv_pkg::OFS_IRQ_STATUS, 32'h00000000);
		// one array in constant mode inside a four-byte window
		opt = ($urandom & dsv_pkg::OPT_WRITE_MASK & 32'hFFFFF8FC) | 32'h00000202;
		pm_u.send({opt, a, 16'h0001, 16'h0008, idx});
		pm_u.beat(5'h02, 0);
		#1 chk("const addr", a + 32'h2, write_addr);
		pm_u.beat(5'h02, 1);
		#1 chk("const wrap", a, write_addr);
		pm_u.beat(5'h04, 0);
		rd(dsv_pkg::OFS_COUNTS, 32'h00000000);
		chk("const final", a, write_addr);
		rd(dsv_pkg::OFS_IRQ_STATUS, 32'h00000003);
		$display("test transfer done");
		print_verdict();
	end
endmodule : dma_dest_register_set_view_tb
`default_nettype wire
